// ==== design/upr_decode.sv ====
/*
  Paged register decode of a serial controller, reached over an 8-bit bus
  with three address lines and active-low read and write strobes.
  Assumes the bus pins are asynchronous: they pass two flip-flops, and a
  strobe acts once on its synchronised falling edge. Status bytes come from
  the controller core on the same clock.
*/
// Function
// RQ1: Three address lines pick one of eight locations.
// RQ2: Second page only while line control is 0xBF.
// RQ3: Location 0 reads rx, writes tx holding.
// RQ4: Divisor mode: location 0 is divisor low.
// RQ5: Divisor mode: location 1 is divisor high.
// RQ6: Zero divisor: location 0 reads revision code.
// RQ7: Zero divisor: location 1 reads identity code.
// RQ8: Location 1 base page: interrupt enable.
// RQ9: Location 2: read status, write queue control.
// RQ10: Line control always reachable at location 3.
// RQ11: Location 4 base page: modem control.
// RQ12: Location 5 base page reads line status.
// RQ13: Location 5 write loads extra feature if enhanced.
// RQ14: Location 6 base page reads modem status.
// RQ15: Location 6 write loads pulse width if enhanced.
// RQ16: Location 7 base page: plain scratch byte.
// RQ17: Second page location 2: enhanced function.
// RQ18: Second page locations 4,5: resume characters.
// RQ19: Second page locations 6,7: stop characters.
// RQ20: Enhanced bits act only with enhanced bit.
// RQ21: Wrong-direction accesses have no side effects.
`timescale 1ns/1ps
`include "upr_regs.svh"

module upr_decode #(
  parameter logic [7:0] REVISION_CODE = 8'h01,  // Arbitrary value.
  parameter logic [7:0] PART_IDENTITY = 8'h5a   // Arbitrary value.
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] rx_holding,
  input wire logic [7:0] interrupt_status,
  input wire logic [7:0] line_status,
  input wire logic [7:0] modem_status,
  output logic rx_read,
  output logic tx_load,
  output logic [7:0] tx_holding,
  output logic queue_load,
  output logic [7:0] queue_control,
  output logic [7:0] divisor_low,
  output logic [7:0] divisor_high,
  output logic [7:0] interrupt_enable,
  output logic [7:0] line_control,
  output logic [7:0] modem_control,
  output logic [7:0] scratch_byte,
  output logic [7:0] enhanced_function,
  output logic [7:0] flow_resume_char_1,
  output logic [7:0] flow_resume_char_2,
  output logic [7:0] flow_stop_char_1,
  output logic [7:0] flow_stop_char_2,
  output logic [7:0] extra_feature,
  output logic [7:0] infrared_pulse_width
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [2:0] addr_s1;
  logic [2:0] addr_s2;
  logic [7:0] din_s1;
  logic [7:0] din_s2;
  logic [1:0] rd_n_s;
  logic [1:0] wr_n_s;
  logic rd_n_d;
  logic wr_n_d;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_s1 <= 3'h0;
      addr_s2 <= 3'h0;
      din_s1 <= 8'h00;
      din_s2 <= 8'h00;
      rd_n_s <= 2'b11;
      wr_n_s <= 2'b11;
      rd_n_d <= 1'b1;
      wr_n_d <= 1'b1;
    end else begin
      addr_s1 <= addr;
      addr_s2 <= addr_s1;
      din_s1 <= data_in;
      din_s2 <= din_s1;
      rd_n_s <= {rd_n_s[0], rd_n};
      wr_n_s <= {wr_n_s[0], wr_n};
      rd_n_d <= rd_n_s[1];
      wr_n_d <= wr_n_s[1];
    end
  end

  // --------------------------------------------------------------------------
  // Page selection
  // --------------------------------------------------------------------------
  logic rd_go;
  logic wr_go;
  logic enh;
  logic div_zero;
  upr_pkg::upr_page_e page;

  function automatic upr_pkg::upr_page_e upr_page_of(input logic [7:0] lc);
    if (lc == `UPR_PAGE2_KEY) begin
      upr_page_of = upr_pkg::UPR_PAGE_ENH; // RQ2
    end else if (lc[`UPR_LCR_DIV_BIT]) begin
      upr_page_of = upr_pkg::UPR_PAGE_DIV;
    end else begin
      upr_page_of = upr_pkg::UPR_PAGE_BASE;
    end
  endfunction

  // A strobe acts on its falling edge only, so a long strobe is one access.
  assign rd_go = rd_n_d & ~rd_n_s[1];
  assign wr_go = wr_n_d & ~wr_n_s[1];
  assign page = upr_page_of(line_control);
  assign enh = enhanced_function[`UPR_EFR_ENH_BIT];
  assign div_zero = (divisor_low == `UPR_ZERO_BYTE) && (divisor_high == `UPR_ZERO_BYTE);

  // --------------------------------------------------------------------------
  // Writes
  // --------------------------------------------------------------------------
  // The controller core masks nothing itself, so enhanced-only bits are
  // cleared here on write when the enhanced bit is off.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_holding <= `UPR_RESET_BYTE;
      queue_control <= `UPR_RESET_BYTE;
      divisor_low <= `UPR_RESET_BYTE;
      divisor_high <= `UPR_RESET_BYTE;
      interrupt_enable <= `UPR_RESET_BYTE;
      line_control <= `UPR_RESET_BYTE;
      modem_control <= `UPR_RESET_BYTE;
      scratch_byte <= `UPR_RESET_BYTE;
      enhanced_function <= `UPR_RESET_BYTE;
      flow_resume_char_1 <= `UPR_RESET_BYTE;
      flow_resume_char_2 <= `UPR_RESET_BYTE;
      flow_stop_char_1 <= `UPR_RESET_BYTE;
      flow_stop_char_2 <= `UPR_RESET_BYTE;
      extra_feature <= `UPR_RESET_BYTE;
      infrared_pulse_width <= `UPR_RESET_BYTE;
    end else if (wr_go) begin // RQ21
      if (addr_s2 == `UPR_LOC_LCTRL) begin
        line_control <= din_s2; // RQ10
      end else begin
        case (page) // RQ1
          upr_pkg::UPR_PAGE_BASE: begin
            case (addr_s2)
              `UPR_LOC_HOLD: tx_holding <= din_s2; // RQ3
              `UPR_LOC_IEN: begin
                interrupt_enable <= enh ? din_s2 : (din_s2 & `UPR_IER_BASE_MASK); // RQ8 RQ20
              end
              `UPR_LOC_ISTAT: begin
                queue_control <= enh ? din_s2 : (din_s2 & `UPR_FCR_BASE_MASK); // RQ9 RQ20
              end
              `UPR_LOC_MCTRL: begin
                modem_control <= enh ? din_s2 : (din_s2 & `UPR_MCR_BASE_MASK); // RQ11 RQ20
              end
              `UPR_LOC_LSTAT: begin
                if (enh) begin
                  extra_feature <= din_s2; // RQ13
                end
              end
              `UPR_LOC_MSTAT: begin
                if (enh) begin
                  infrared_pulse_width <= din_s2; // RQ15
                end
              end
              `UPR_LOC_SCRATCH: scratch_byte <= din_s2; // RQ16
              default: begin
              end
            endcase
          end
          upr_pkg::UPR_PAGE_DIV: begin
            case (addr_s2)
              `UPR_LOC_HOLD: divisor_low <= din_s2; // RQ4
              `UPR_LOC_IEN: divisor_high <= din_s2; // RQ5
              default: begin
              end
            endcase
          end
          upr_pkg::UPR_PAGE_ENH: begin
            case (addr_s2)
              `UPR_LOC_ISTAT: enhanced_function <= din_s2; // RQ17
              `UPR_LOC_MCTRL: flow_resume_char_1 <= din_s2; // RQ18
              `UPR_LOC_LSTAT: flow_resume_char_2 <= din_s2; // RQ18
              `UPR_LOC_MSTAT: flow_stop_char_1 <= din_s2; // RQ19
              `UPR_LOC_SCRATCH: flow_stop_char_2 <= din_s2; // RQ19
              default: begin
              end
            endcase
          end
          default: begin
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  logic [7:0] next_data_out;

  always_comb begin
    next_data_out = 8'h00;
    if (addr_s2 == `UPR_LOC_LCTRL) begin
      next_data_out = line_control; // RQ10
    end else begin
      case (page)
        upr_pkg::UPR_PAGE_BASE: begin
          case (addr_s2)
            `UPR_LOC_HOLD: next_data_out = rx_holding; // RQ3
            `UPR_LOC_IEN: next_data_out = interrupt_enable; // RQ8
            `UPR_LOC_ISTAT: begin
              next_data_out = enh ? interrupt_status
                                  : (interrupt_status & `UPR_ISR_BASE_MASK); // RQ9 RQ20
            end
            `UPR_LOC_MCTRL: next_data_out = modem_control; // RQ11
            `UPR_LOC_LSTAT: next_data_out = line_status; // RQ12
            `UPR_LOC_MSTAT: next_data_out = modem_status; // RQ14
            `UPR_LOC_SCRATCH: next_data_out = scratch_byte; // RQ16
            default: next_data_out = 8'h00;
          endcase
        end
        upr_pkg::UPR_PAGE_DIV: begin
          case (addr_s2)
            `UPR_LOC_HOLD: next_data_out = div_zero ? REVISION_CODE : divisor_low; // RQ4 RQ6
            `UPR_LOC_IEN: next_data_out = div_zero ? PART_IDENTITY : divisor_high; // RQ5 RQ7
            default: next_data_out = 8'h00;
          endcase
        end
        upr_pkg::UPR_PAGE_ENH: begin
          case (addr_s2)
            `UPR_LOC_ISTAT: next_data_out = enhanced_function; // RQ17
            `UPR_LOC_MCTRL: next_data_out = flow_resume_char_1; // RQ18
            `UPR_LOC_LSTAT: next_data_out = flow_resume_char_2; // RQ18
            `UPR_LOC_MSTAT: next_data_out = flow_stop_char_1; // RQ19
            `UPR_LOC_SCRATCH: next_data_out = flow_stop_char_2; // RQ19
            default: next_data_out = 8'h00;
          endcase
        end
        default: next_data_out = 8'h00;
      endcase
    end
  end

  // Data is driven for as long as the synchronised read strobe is low.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      data_out <= next_data_out;
      data_oe <= ~rd_n_s[1];
    end
  end

  // --------------------------------------------------------------------------
  // Access pulses to the controller core
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_read <= 1'b0;
      tx_load <= 1'b0;
      queue_load <= 1'b0;
    end else begin
      rx_read <= rd_go && page == upr_pkg::UPR_PAGE_BASE && addr_s2 == `UPR_LOC_HOLD; // RQ3
      tx_load <= wr_go && page == upr_pkg::UPR_PAGE_BASE && addr_s2 == `UPR_LOC_HOLD; // RQ3
      queue_load <= wr_go && page == upr_pkg::UPR_PAGE_BASE && addr_s2 == `UPR_LOC_ISTAT; // RQ9
    end
  end

endmodule

// ==== design/upr_pkg.sv ====
/*
  Types of the paged register decode; the bench files do not use them.
  Assumes nothing of its surroundings.
*/
package upr_pkg;
  typedef logic [7:0] upr_byte_t;
  typedef enum logic [1:0] {
    UPR_PAGE_BASE = 2'b00,
    UPR_PAGE_DIV = 2'b01,
    UPR_PAGE_ENH = 2'b11
  } upr_page_e;
endpackage

// ==== design/upr_regs.svh ====
/*
  Address map, field positions and fixed codes of the paged register decode.
  Assumes inclusion by the decode module only; the bench files use literal values.
*/
`ifndef UPR_REGS_SVH
`define UPR_REGS_SVH

// ----------------------------------------------------------------------------
// Locations on the three address lines
// ----------------------------------------------------------------------------
`define UPR_LOC_HOLD 3'h0
`define UPR_LOC_IEN 3'h1
`define UPR_LOC_ISTAT 3'h2
`define UPR_LOC_LCTRL 3'h3
`define UPR_LOC_MCTRL 3'h4
`define UPR_LOC_LSTAT 3'h5
`define UPR_LOC_MSTAT 3'h6
`define UPR_LOC_SCRATCH 3'h7

// ----------------------------------------------------------------------------
// Fields and page keys
// ----------------------------------------------------------------------------
`define UPR_LCR_DIV_BIT 7
`define UPR_EFR_ENH_BIT 4
`define UPR_PAGE2_KEY 8'hbf
`define UPR_ZERO_BYTE 8'h00
`define UPR_IER_BASE_MASK 8'h0f
`define UPR_ISR_BASE_MASK 8'hcf
`define UPR_FCR_BASE_MASK 8'hcf
`define UPR_MCR_BASE_MASK 8'h1f
`define UPR_RESET_BYTE 8'h00

`endif

// ==== testbench/uart_paged_register_decode_tb_top.sv ====
/*
  Self-checking bench of the paged register decode.
  Assumes the host model tasks and the bound checker.
*/
`timescale 1ns/1ps
module uart_paged_register_decode_tb_top;
  localparam logic [7:0] REV_CODE = 8'h01;  // Arbitrary value.
  localparam logic [7:0] PART_ID = 8'h5a;   // Arbitrary value.
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rd_n, wr_n, data_oe, rx_read, tx_load, queue_load;
  logic [2:0] addr;
  logic [7:0] data_in, data_out, rx_holding, interrupt_status, line_status, modem_status;
  logic [7:0] tx_holding, queue_control, divisor_low, divisor_high, interrupt_enable;
  logic [7:0] line_control, modem_control, scratch_byte, enhanced_function, extra_feature;
  logic [7:0] flow_resume_char_1, flow_resume_char_2, flow_stop_char_1, flow_stop_char_2;
  logic [7:0] infrared_pulse_width;
  int errors = 0;
  int checks_done = 0;
  int tx_pulses = 0;
  int rx_pulses = 0;
  int queue_pulses = 0;

  always #5 clk = ~clk;

  // Each access must give exactly one core pulse, however long its strobe.
  always @(posedge clk) begin
    if (tx_load === 1'b1) begin
      tx_pulses++;
    end
    if (rx_read === 1'b1) begin
      rx_pulses++;
    end
    if (queue_load === 1'b1) begin
      queue_pulses++;
    end
  end

  upr_decode #(.REVISION_CODE(REV_CODE), .PART_IDENTITY(PART_ID)) u_upr_decode (.clk, .rstn,
    .addr, .data_in, .rd_n, .wr_n, .data_out, .data_oe, .rx_holding, .interrupt_status,
    .line_status, .modem_status, .rx_read, .tx_load, .tx_holding, .queue_load, .queue_control,
    .divisor_low, .divisor_high, .interrupt_enable, .line_control, .modem_control,
    .scratch_byte, .enhanced_function, .flow_resume_char_1, .flow_resume_char_2,
    .flow_stop_char_1, .flow_stop_char_2, .extra_feature, .infrared_pulse_width);

  upr_host_model u_upr_host_model (.clk, .addr, .data_in, .rd_n, .wr_n, .data_out, .data_oe);

  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    u_upr_host_model.write_reg(a, d);
  endtask

  // A read that never gets the bus enable ends the run at once.
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit ok;
    u_upr_host_model.read_reg(a, d, ok);
    if (!ok) begin
      errors++;
      $display("CHECK FAILED at %0t: no read enable at %h", $time, a);
      finish_test();
    end
    chk(d, exp);
  endtask

  initial begin
    rx_holding = 8'h3c;
    interrupt_status = 8'hff;
    line_status = 8'h61;
    modem_status = 8'hb0;
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    chk(line_control, 8'h00);
    wr(3'h7, 8'ha5);
    rd(3'h7, 8'ha5);
    wr(3'h1, 8'hff);
    rd(3'h1, 8'h0f);
    wr(3'h4, 8'hff);
    rd(3'h4, 8'h1f);
    wr(3'h2, 8'hff);
    chk(queue_control, 8'hcf);
    rd(3'h2, 8'hcf);
    wr(3'h0, 8'h5e);
    chk(tx_holding, 8'h5e);
    rd(3'h0, 8'h3c);
    rd(3'h5, 8'h61);
    rd(3'h6, 8'hb0);
    wr(3'h5, 8'h77);
    wr(3'h6, 8'h66);
    chk(extra_feature, 8'h00);
    chk(infrared_pulse_width, 8'h00);
    chk(scratch_byte, 8'ha5);
    $display("base page test done");
    wr(3'h3, 8'h80);
    rd(3'h0, REV_CODE);
    rd(3'h1, PART_ID);
    wr(3'h0, 8'h12);
    rd(3'h0, 8'h12);
    rd(3'h1, 8'h00);
    wr(3'h1, 8'h34);
    rd(3'h1, 8'h34);
    wr(3'h7, 8'h99);
    chk(scratch_byte, 8'ha5);
    rd(3'h3, 8'h80);
    $display("divisor test done");
    wr(3'h3, 8'hbf);
    wr(3'h2, 8'h10);
    rd(3'h2, 8'h10);
    for (int a = 4; a < 8; a++) begin
      wr(3'(a), 8'(8'h20 + a));
    end
    for (int a = 4; a < 8; a++) begin
      rd(3'(a), 8'(8'h20 + a));
    end
    chk(flow_stop_char_2, 8'h27);
    wr(3'h0, 8'h55);
    chk(divisor_low, 8'h12);
    rd(3'h3, 8'hbf);
    $display("second page test done");
    wr(3'h3, 8'h03);
    wr(3'h5, 8'h77);
    chk(extra_feature, 8'h77);
    wr(3'h6, 8'h66);
    chk(infrared_pulse_width, 8'h66);
    wr(3'h1, 8'hff);
    rd(3'h1, 8'hff);
    rd(3'h2, 8'hff);
    rd(3'h7, 8'ha5);
    chk(8'(tx_pulses), 8'h01);
    chk(8'(rx_pulses), 8'h01);
    chk(8'(queue_pulses), 8'h01);
    $display("enhanced test done");
    finish_test();
  end
endmodule

// ==== testbench/upr_decode_asserts.sv ====
/*
  Checker of the paged register decode, bound to the decode module.
  Assumes one clock and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
module upr_decode_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic data_oe,
  input wire logic rx_read,
  input wire logic tx_load,
  input wire logic queue_load,
  input wire logic [7:0] divisor_low,
  input wire logic [7:0] divisor_high,
  input wire logic [7:0] interrupt_enable,
  input wire logic [7:0] line_control,
  input wire logic [7:0] modem_control,
  input wire logic [7:0] scratch_byte,
  input wire logic [7:0] enhanced_function,
  input wire logic [7:0] flow_resume_char_1,
  input wire logic [7:0] extra_feature,
  input wire logic [7:0] infrared_pulse_width
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_oe_delay: assert property ($fell(rd_n) |-> ##3 data_oe)
    else $error("read enable late");
  a_scratch_write: assert property ($fell(wr_n) && addr == 3'h7 && !line_control[7]
    |-> ##3 scratch_byte == $past(data_in, 3)) else $error("scratch write lost");
  a_tx_base: assert property (tx_load |-> !line_control[7])
    else $error("tx load outside base page");
  a_rx_base: assert property (rx_read |-> !line_control[7] && data_oe)
    else $error("rx read without base page read");
  a_queue_base: assert property (queue_load |-> !line_control[7])
    else $error("queue load outside base page");
  a_div_gate: assert property ($changed(divisor_low) || $changed(divisor_high)
    |-> line_control[7] && line_control != 8'hbf) else $error("divisor written off page");
  a_page2_gate: assert property ($changed(enhanced_function) || $changed(flow_resume_char_1)
    |-> line_control == 8'hbf) else $error("second page written without key");
  a_base_gate: assert property ($changed(scratch_byte) || $changed(modem_control)
    |-> !line_control[7]) else $error("base register written off page");
  a_enh_mask: assert property ($changed(interrupt_enable)
    |-> enhanced_function[4] || interrupt_enable[7:4] == 4'h0) else $error("upper bits open");
  a_extra_gate: assert property ($changed(extra_feature) || $changed(infrared_pulse_width)
    |-> enhanced_function[4] && !line_control[7]) else $error("extra register written");

  c_tx: cover property (tx_load);
  c_extra: cover property ($changed(extra_feature));
  c_div: cover property ($changed(divisor_low));
endmodule

bind upr_decode upr_decode_asserts u_upr_decode_asserts (.clk, .rstn, .addr, .data_in, .rd_n,
  .wr_n, .data_oe, .rx_read, .tx_load, .queue_load, .divisor_low, .divisor_high,
  .interrupt_enable, .line_control, .modem_control, .scratch_byte, .enhanced_function,
  .flow_resume_char_1, .extra_feature, .infrared_pulse_width);

// ==== testbench/upr_host_model.sv ====
/*
  Host processor model that drives the parallel register bus.
  Assumes the decode samples the bus through two flip-flops on clk.
*/
`timescale 1ns/1ps
module upr_host_model (
  input wire logic clk,
  output logic [2:0] addr,
  output logic [7:0] data_in,
  output logic rd_n,
  output logic wr_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  initial begin
    addr = 3'h0;
    data_in = 8'h00;
    rd_n = 1'b1;
    wr_n = 1'b1;
  end

  // The write strobe stays low four edges so the synchronised falling edge is seen.
  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    addr = a;
    data_in = d;
    repeat (2) @(posedge clk);
    #1 wr_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 wr_n = 1'b1;
    // A released bus must not keep showing the last byte.
    data_in = ~d;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic read_reg(input logic [2:0] a, output logic [7:0] d, output bit ok);
    int n;
    addr = a;
    ok = 1'b0;
    d = 8'h00;
    repeat (2) @(posedge clk);
    #1 rd_n = 1'b0;
    for (n = 0; n < 8 && data_oe !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (data_oe === 1'b1) begin
      d = data_out;
      ok = 1'b1;
    end
    rd_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask
endmodule
